// >>> core/fifo_status_defs.svh
/*
 * Register offsets, field positions, reset values and timing figures of the
 * FIFO status and transmit length registers.
 * Assumes it is included by bare name from design files under core/.
 */
`ifndef FIFO_STATUS_DEFS_SVH
`define FIFO_STATUS_DEFS_SVH

// Register addresses as seen in the five-bit address field of a command byte
`define FIFO_FILL_STATUS_OFFSET       5'h1c
`define TX_COUNT_UPPER_OFFSET         5'h1d
`define TX_COUNT_LOWER_PARTIAL_OFFSET 5'h1e
`define FIFO_DATA_OFFSET              5'h1f

// Field positions
`define FIFO_OVERFLOW_BIT             7
`define CMD_READ_BIT                  6
`define CMD_CONTINUOUS_BIT            5
`define PARTIAL_FLAG_BIT              0

// Reset values and capacity
`define TX_LENGTH_RESET               8'h00
`define FIFO_LEVEL_RESET              7'h00
`define FIFO_CAPACITY                 7'h7f

// Timing: system clock and fastest host serial clock, in Hz
`define SYS_CLK_HZ                    10000000
`define HOST_SCLK_HZ                  2000000
`define SYS_CLKS_PER_SCLK             (`SYS_CLK_HZ / `HOST_SCLK_HZ)

`endif

// >>> core/fifo_status_pkg.sv
/*
 * Types shared by the FIFO status and transmit length register block.
 * Assumes fifo_status_defs.svh supplies the numeric constants.
 */
package fifo_status_pkg;

    typedef enum logic {
        LINK_CMD,
        LINK_DATA
    } link_phase_e;

    // State of one serial frame; cleared whenever the host deselects
    typedef struct packed {
        link_phase_e phase;
        logic [2:0]  bit_cnt;
        logic [6:0]  shift;
        logic        rd;
        logic        cont;
        logic [4:0]  addr;
        logic [7:0]  tx_sh;
        logic        miso;
        logic        miso_oe;
    } link_frame_s;

    // Events handed to the system clock domain; survive deselect
    typedef struct packed {
        logic       wr_tgl;
        logic       rd_tgl;
        logic [4:0] ev_addr;
        logic [7:0] wr_data;
    } link_event_s;

    typedef struct packed {
        logic       wr_seen;
        logic       rd_seen;
        logic [6:0] level;
        logic       overflow;
        logic [7:0] len_upper;
        logic [7:0] len_lower;
        logic [2:0] partial_bits;
        logic [7:0] rd_data;
        logic [7:0] tx_byte;
        logic       tx_valid;
    } core_s;

endpackage

// >>> core/fifo_status_tx_length_regs.sv
/*
 * FIFO fill status and transmit length registers behind a serial host link,
 * with a small byte buffer in the transmit data path.
 * Assumes: clk is the 10 MHz device clock, srst a synchronous reset on it,
 * sclk the host serial clock (no faster than 2 MHz), ss_n the active-low
 * slave select, chip_en the chip enable pin, and tx_ready/tx_eof come from
 * the transmitter on clk.
 */
// Summary of operation
// [R1] Overflow bit set when a pushed byte is refused (buffer full)
// [R2] Low seven status bits give byte count
// [R3] Upper length register holds count bits 11:4
// [R4] Lengths clear at reset, disable, end-of-frame
// [R5] Lower register top nibble holds bits 3:0
// [R6] Partial bit count used only when flagged
// [R7] Lowest bit flags a short final byte
// [R8] Host serial clock at most 2 MHz
// [R9] Count tracks pushes and pops, saturating
`timescale 1ns/1ps
`include "fifo_status_defs.svh"

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [AW:0]                 count;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic  push;
    logic  pop;

    assign in_ready  = (q.count != (AW+1)'(DEPTH));
    assign out_valid = (q.count != '0);
    assign out_data  = q.mem[q.rptr];

    always_comb begin
        d    = q;
        push = in_valid && in_ready;
        pop  = out_valid && out_ready;
        if (push) begin
            d.mem[q.wptr] = in_data;
            d.wptr        = (q.wptr == AW'(DEPTH - 1)) ? '0 : q.wptr + 1'b1;
        end
        if (pop) begin
            d.rptr = (q.rptr == AW'(DEPTH - 1)) ? '0 : q.rptr + 1'b1;
        end
        d.count = q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (flush) begin
            d.wptr  = '0;
            d.rptr  = '0;
            d.count = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// One signal crossing into the clk domain through a chain of flip-flops
module bit_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      sync_out
);
    typedef struct packed {
        logic [STAGES-1:0] stage;
    } sync_s;

    sync_s q;
    sync_s d;

    // Only the last stage is read; the first may still be settling
    assign sync_out = q.stage[STAGES-1];

    always_comb begin
        d       = q;
        d.stage = {q.stage[STAGES-2:0], async_in};
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

module fifo_status_tx_length_regs #(
    parameter int BUF_DEPTH = 8
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        chip_en,
    input  wire logic        sclk,
    input  wire logic        ss_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    input  wire logic        tx_eof,
    input  wire logic        tx_ready,
    output logic      [7:0]  tx_byte,
    output logic             tx_valid,
    output logic      [11:0] tx_count,
    output logic      [2:0]  tx_partial_bits,
    output logic             tx_partial_flag,
    output logic             fifo_overflow
);
    fifo_status_pkg::link_frame_s fq;
    fifo_status_pkg::link_frame_s fd;
    fifo_status_pkg::link_event_s eq;
    fifo_status_pkg::link_event_s ed;
    fifo_status_pkg::core_s       q;
    fifo_status_pkg::core_s       d;

    logic       frame_rst;
    logic [7:0] byte_in;
    logic       wr_ev;
    logic       rd_ev;
    logic       en;
    logic       push_req;
    logic       push_ok;
    logic       push_acc;
    logic       drained;
    logic       buf_in_ready;
    logic [7:0] buf_data;
    logic       buf_valid;
    logic       buf_ready;
    logic       wr_lvl;
    logic       rd_lvl;

    // Deselect ends a frame even though sclk has stopped, hence the async clear
    assign frame_rst = ss_n | srst;

    // Link side: command byte, then data bytes, MSB first. Sampled on rising
    // sclk; miso also changes on rising sclk for the host to take on falling.
    always_comb begin
        fd      = fq;
        ed      = eq;
        byte_in = {fq.shift, mosi};
        fd.shift   = byte_in[6:0];
        fd.bit_cnt = fq.bit_cnt + 3'h1;
        fd.miso_oe = 1'b0;
        if (fq.phase == fifo_status_pkg::LINK_DATA && fq.rd) begin
            fd.miso_oe = 1'b1;
            // Read data was fetched one sclk earlier; with sclk at 2 MHz the
            // handover takes well under one sclk period [R8]
            if (fq.bit_cnt == 3'h0) begin
                {fd.miso, fd.tx_sh} = {q.rd_data, 1'b0};
            end else begin
                {fd.miso, fd.tx_sh} = {fq.tx_sh, 1'b0};
            end
        end
        if (fq.bit_cnt == 3'h7) begin
            if (fq.phase == fifo_status_pkg::LINK_CMD) begin
                fd.phase = fifo_status_pkg::LINK_DATA;
                fd.rd    = byte_in[`CMD_READ_BIT];
                fd.cont  = byte_in[`CMD_CONTINUOUS_BIT];
                fd.addr  = byte_in[4:0];
                if (byte_in[`CMD_READ_BIT]) begin
                    ed.rd_tgl  = ~eq.rd_tgl;
                    ed.ev_addr = byte_in[4:0];
                end
            end else begin
                if (!fq.rd) begin
                    ed.wr_tgl  = ~eq.wr_tgl;
                    ed.ev_addr = fq.addr;
                    ed.wr_data = byte_in;
                end else if (fq.cont) begin
                    ed.rd_tgl  = ~eq.rd_tgl;
                    ed.ev_addr = fq.addr + 5'h01;
                end
                if (fq.cont) begin
                    fd.addr = fq.addr + 5'h01;
                end else begin
                    fd.phase = fifo_status_pkg::LINK_CMD;
                end
            end
        end
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            fq <= '0;
        end else begin
            fq <= fd;
        end
    end

    // Toggles must not jump on deselect, or the core would see a false event
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            eq <= '0;
        end else begin
            eq <= ed;
        end
    end

    bit_sync #(
        .STAGES (2)
    ) u_en_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (chip_en),
        .sync_out (en)
    );

    bit_sync #(
        .STAGES (2)
    ) u_wr_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (eq.wr_tgl),
        .sync_out (wr_lvl)
    );

    bit_sync #(
        .STAGES (2)
    ) u_rd_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in (eq.rd_tgl),
        .sync_out (rd_lvl)
    );

    // An event is a change of the synchronised toggle
    assign wr_ev    = wr_lvl ^ q.wr_seen;
    assign rd_ev    = rd_lvl ^ q.rd_seen;
    assign push_req = wr_ev && (eq.ev_addr == `FIFO_DATA_OFFSET);
    assign push_ok  = push_req && (q.level != `FIFO_CAPACITY) && en;
    assign push_acc = push_ok && buf_in_ready;
    assign drained  = q.tx_valid && tx_ready;
    assign buf_ready = !q.tx_valid || tx_ready;

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk       (clk),
        .srst      (srst),
        .flush     (!en),
        .in_data   (eq.wr_data),
        .in_valid  (push_ok),
        .in_ready  (buf_in_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_ready)
    );

    always_comb begin
        d = q;
        d.wr_seen = wr_lvl;
        d.rd_seen = rd_lvl;

        // Output stage keeps tx_byte on a flip-flop
        if (buf_valid && buf_ready) begin
            d.tx_byte  = buf_data;
            d.tx_valid = 1'b1;
        end else if (tx_ready) begin
            d.tx_valid = 1'b0;
        end

        // Level counts every byte taken in and not yet handed on [R9]
        d.level = q.level + {6'h00, push_acc} - {6'h00, drained};

        // A clear on end-of-frame loses to a refused push in the same cycle [R1]
        if (tx_eof) begin
            d.overflow = 1'b0;
        end
        if (push_req && !push_acc) begin
            d.overflow = 1'b1; // [R1] [R9]
        end

        // End-of-frame clear first, so a write in the same cycle wins [R4]
        if (tx_eof) begin
            d.len_upper = `TX_LENGTH_RESET;
            d.len_lower = `TX_LENGTH_RESET;
        end
        if (wr_ev && eq.ev_addr == `TX_COUNT_UPPER_OFFSET) begin
            d.len_upper = eq.wr_data; // [R3]
        end
        if (wr_ev && eq.ev_addr == `TX_COUNT_LOWER_PARTIAL_OFFSET) begin
            d.len_lower = eq.wr_data; // [R5] [R6] [R7]
        end

        // Disabled chip holds lengths and FIFO empty [R4]
        if (!en) begin
            d.len_upper = `TX_LENGTH_RESET;
            d.len_lower = `TX_LENGTH_RESET;
            d.level     = `FIFO_LEVEL_RESET;
            d.overflow  = 1'b0;
            d.tx_valid  = 1'b0;
        end

        // Bit count is passed on only while the short-byte flag is set [R6] [R7]
        d.partial_bits = d.len_lower[`PARTIAL_FLAG_BIT] ? d.len_lower[3:1] : 3'h0;

        if (rd_ev) begin
            case (eq.ev_addr)
                `FIFO_FILL_STATUS_OFFSET: begin
                    d.rd_data = {q.overflow, q.level}; // [R1] [R2]
                end
                `TX_COUNT_UPPER_OFFSET: begin
                    d.rd_data = q.len_upper;
                end
                `TX_COUNT_LOWER_PARTIAL_OFFSET: begin
                    d.rd_data = q.len_lower;
                end
                default: begin
                    d.rd_data = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0; // [R4]
        end else begin
            q <= d;
        end
    end

    assign miso            = fq.miso;
    assign miso_oe         = fq.miso_oe;
    assign tx_byte         = q.tx_byte;
    assign tx_valid        = q.tx_valid;
    assign tx_count        = {q.len_upper, q.len_lower[7:4]}; // [R3] [R5]
    assign tx_partial_bits = q.partial_bits;
    assign tx_partial_flag = q.len_lower[`PARTIAL_FLAG_BIT];
    assign fifo_overflow   = q.overflow;
endmodule

// >>> test/fifo_regs_chk.sv
/*
 * Assertion checker for the FIFO status and transmit length block.
 * Assumes it is bound to the block's top module and sees only its ports.
 */
`timescale 1ns/1ps
module fifo_regs_chk #(
    parameter int BUF_DEPTH = 8
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        chip_en,
    input wire logic        sclk,
    input wire logic        ss_n,
    input wire logic        mosi,
    input wire logic        miso,
    input wire logic        miso_oe,
    input wire logic        tx_eof,
    input wire logic        tx_ready,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_valid,
    input wire logic [11:0] tx_count,
    input wire logic [2:0]  tx_partial_bits,
    input wire logic        tx_partial_flag,
    input wire logic        fifo_overflow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_reset_zero: assert property ($fell(srst) |-> tx_count == 12'h000 && !fifo_overflow)
        else $error("outputs not clear after reset");
    // Link idle for 8 cycles, so no write can land on the clearing edge
    a_eof_clear: assert property (tx_eof && ss_n && $past(ss_n, 8) |=>
        tx_count == 12'h000 && !tx_partial_flag && !fifo_overflow)
        else $error("lengths kept after end of frame");
    a_chip_off: assert property (!chip_en [*4] |=> tx_count == 12'h000 && !fifo_overflow)
        else $error("state kept while disabled");
    a_flag_gates: assert property (!tx_partial_flag |-> tx_partial_bits == 3'h0)
        else $error("partial bits without flag");
    a_len_steady: assert property (ss_n && $past(ss_n, 8) && !tx_eof && chip_en
        && $past(chip_en, 4) |=> $stable(tx_count) && $stable(tx_partial_bits))
        else $error("length changed without a write");
    a_ovf_sticky: assert property (fifo_overflow && !tx_eof && chip_en
        && $past(chip_en, 4) |=> fifo_overflow)
        else $error("overflow dropped");
    a_tx_hold: assert property (tx_valid && !tx_ready && chip_en |=>
        tx_valid && $stable(tx_byte))
        else $error("stalled byte not held");
    a_miso_idle: assert property (ss_n |-> !miso_oe)
        else $error("miso driven while deselected");
endmodule

bind fifo_status_tx_length_regs fifo_regs_chk #(.BUF_DEPTH(BUF_DEPTH)) u_fifo_regs_chk (
    .clk(clk), .srst(srst), .chip_en(chip_en), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .tx_eof(tx_eof), .tx_ready(tx_ready),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_count(tx_count),
    .tx_partial_bits(tx_partial_bits), .tx_partial_flag(tx_partial_flag),
    .fifo_overflow(fifo_overflow));

// >>> test/host_link_model.sv
/*
 * Host side of the serial register link: one command byte, one data byte.
 * Assumes the bench never starts a frame while another is in flight.
 */
`timescale 1ns/1ps
module host_link_model (
    output logic     sclk,
    output logic     ss_n,
    output logic     mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        // Raised after the bench's reset edge so the frame clear is seen
        #2 ss_n = 1'b1;
    end

    // Clock stands still between frames; 2 MHz bit rate
    task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        rd = 8'h00;
        // Offset keeps link edges clear of system clock edges
        #13 ss_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = sh[i];
            #250 sclk = 1'b1;
            #250;
            if (i < 8) rd[i[2:0]] = miso;
            sclk = 1'b0;
        end
        #250 ss_n = 1'b1;
        // Released line shows no stale value
        mosi = ~mosi;
        #500;
    endtask
endmodule

// >>> test/tb.sv
/*
 * Self-checking bench for the FIFO status and transmit length block.
 * Assumes the host link model and the bound checker are compiled first.
 */
`timescale 1ns/1ps
`include "fifo_status_defs.svh"
module tb;
    logic        clk, srst, chip_en, tx_eof, tx_ready;
    logic        sclk, ss_n, mosi, miso, miso_oe, miso_line, tx_valid, pflag, ovf;
    logic [7:0]  tx_byte, r, up, lo, q[$];
    logic [11:0] cnt;
    logic [2:0]  pbits;
    int          n_fail, compares, taken;

    fifo_status_tx_length_regs #(.BUF_DEPTH(8)) u_fifo_status_tx_length_regs (
        .clk(clk), .srst(srst), .chip_en(chip_en), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .tx_eof(tx_eof), .tx_ready(tx_ready),
        .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_count(cnt), .tx_partial_bits(pbits),
        .tx_partial_flag(pflag), .fifo_overflow(ovf));
    host_link_model u_host_link_model (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso_line));
    // Undriven miso toggles so a stale bit cannot pass
    assign miso_line = miso_oe ? miso : sclk;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [2:0] exp_bits(input logic [7:0] v);
        return v[0] ? v[3:1] : 3'h0;
    endfunction

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] x;
        @(negedge clk);
        u_host_link_model.frame({3'h0, a}, d, x);
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk);
        u_host_link_model.frame({3'h2, a}, 8'h00, d);
    endtask

    task automatic pulse_eof;
        repeat (4) @(posedge clk);
        tx_eof <= 1'b1;
        @(posedge clk) tx_eof <= 1'b0;
        @(negedge clk);
    endtask

    task automatic end_of_test;
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            check(tx_byte, q.pop_front());
            taken++;
        end
    end

    initial begin
        chip_en = 1'b1;
        tx_eof = 1'b0;
        tx_ready = 1'b0;
        n_fail = 0;
        compares = 0;
        taken = 0;
        void'($urandom(32'hfe2d17d6));
        // A clean rising edge so the asynchronously cleared link state starts known
        #1 srst = 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        wr(`FIFO_FILL_STATUS_OFFSET, 8'hff);
        rd(`FIFO_FILL_STATUS_OFFSET, r);
        check(r, 8'h00);
        rd(`TX_COUNT_UPPER_OFFSET, r);
        check(r, `TX_LENGTH_RESET);
        for (int n = 0; n < 6; n++) begin
            up = 8'($urandom);
            lo = (n == 0) ? 8'h0e : (n == 1) ? 8'hff : 8'($urandom);
            wr(`TX_COUNT_UPPER_OFFSET, up);
            wr(`TX_COUNT_LOWER_PARTIAL_OFFSET, lo);
            check(cnt, {up, lo[7:4]});
            check(pflag, lo[0]);
            check(pbits, exp_bits(lo));
            rd(`TX_COUNT_UPPER_OFFSET, r);
            check(r, up);
            rd(`TX_COUNT_LOWER_PARTIAL_OFFSET, r);
            check(r, lo);
        end
        pulse_eof;
        check(cnt, 12'h000);
        check(pflag, 1'b0);
        check(pbits, 3'h0);
        wr(`TX_COUNT_UPPER_OFFSET, 8'h5a);
        check(cnt, 12'h5a0);
        @(posedge clk) chip_en <= 1'b0;
        repeat (6) @(posedge clk);
        chip_en <= 1'b1;
        @(negedge clk);
        check(cnt, 12'h000);
        repeat (4) @(posedge clk);
        rd(`TX_COUNT_UPPER_OFFSET, r);
        check(r, 8'h00);
        // Transmitter stalled: fill the buffer past its depth
        for (int n = 0; n < 12; n++) begin
            if (n == 5) begin
                rd(`FIFO_FILL_STATUS_OFFSET, r);
                check(r, 8'h05);
            end
            q.push_back(8'($urandom));
            wr(`FIFO_DATA_OFFSET, q[$]);
        end
        rd(`FIFO_FILL_STATUS_OFFSET, r);
        check(r[7], 1'b1);
        check(r[6:0], 7'h09);
        check(ovf, 1'b1);
        repeat (60) @(posedge clk) tx_ready <= 1'($urandom);
        @(posedge clk) tx_ready <= 1'b1;
        repeat (20) @(posedge clk);
        check(12'(taken), 12'h009);
        rd(`FIFO_FILL_STATUS_OFFSET, r);
        check(r, 8'h80);
        pulse_eof;
        rd(`FIFO_FILL_STATUS_OFFSET, r);
        check(r, 8'h00);
        end_of_test;
    end

    initial begin
        #1000000;
        n_fail++;
        end_of_test;
    end
endmodule
